// ---- shared/dio_cond_regs.vh ----
// Register map, field positions, reset values and encodings of the drive I/O conditioning block.
// Assumes a 16-bit register port with byte addresses on word boundaries.
`ifndef DIO_COND_REGS_VH
`define DIO_COND_REGS_VH

// Global registers
`define DIO_CTRL 8'h00
`define DIO_MISTOL 8'h04
`define DIO_OUTCFG 8'h08
`define DIO_REFQ 8'h0C
`define DIO_STATUS 8'h10
`define DIO_IRQSTAT 8'h14
`define DIO_IRQMASK 8'h18

// Channel window: addr[7:6] selects it, addr[5] the channel, addr[4:2] the setting
`define DIO_CH_WIN 2'h1
// Scaled value window: addr[7:6] selects it, addr[5:2] the channel
`define DIO_VAL_WIN 2'h2
`define DIO_K_P1X 3'h0
`define DIO_K_P1Y 3'h1
`define DIO_K_P2X 3'h2
`define DIO_K_P2Y 3'h3
`define DIO_K_WBTH 3'h4
`define DIO_K_ROUTE 3'h5
`define DIO_K_SMOOTH 3'h6
`define DIO_K_DBAND 3'h7

// Field positions
`define DIO_CTRL_STO_EN 0
`define DIO_OUT_SRC_HI 4
`define DIO_OUT_INV 8
`define DIO_ST_SHUT 0
`define DIO_ST_FAULT 1
`define DIO_ST_CHA 2
`define DIO_ST_CHB 3
`define DIO_ST_WB 4
`define DIO_EV_FAULT 0
`define DIO_EV_SHUT 1
`define DIO_EV_WB 2

// Reset values
`define DIO_CTRL_RST 16'h0000
`define DIO_MISTOL_RST 16'h03E8
`define DIO_OUTCFG_RST 16'h0000
`define DIO_REFQ_RST 16'h4000
`define DIO_P2X_RST 16'h2710
`define DIO_P2Y_RST 16'h4000
`define DIO_WBTH_RST 16'h8000
`define DIO_DBAND_RST 16'h0000
`define DIO_CFG_RST 16'h0000

// Percent scale: one shifted left by this many bits stands for 100 %
`define DIO_PCT_SHIFT 14
// Divider steps, one per quotient bit
`define DIO_DIV_STEPS 6'h22

`endif

// ---- hw/dio_signal_cond.v ----
// Drive I/O conditioning: paired safety input, one digital output, analog scaling channels.
// Assumes analog samples in signed millivolts from on-chip logic on mclk; safety pins are asynchronous.
// Operation
// - Inputs A and B form one safety input.
// - Shutdown selectable only when enabled in configuration.
// - Both high deselects, both low removes torque.
// - Differing channels raise a fault flag.
// - Output follows chosen status bit; zero forces off.
// - Optional inversion of the output bit.
// - Two-point linear characteristic per analog input.
// - Point settings per channel, selected by index.
// - Output points are percent of reference quantity.
// - Input below threshold reports wire break.
// - Scaled value routed to chosen consumer input.
// - Optional low-pass smoothing of each input.
// - Dead band around zero forces exact zero.
// - Dead band width resets to zero.
//
// Design decisions made here: the address map and the plain strobed port.
`timescale 1ns/1ps
`include "dio_cond_regs.vh"

module dio_signal_cond #(
  parameter NCH = 2,
  parameter NCONS = 4
) (
  input wire mclk,
  input wire rst_n,
  input wire [7:0] regAddr,
  input wire [15:0] regWdata,
  input wire regWrite,
  input wire regRead,
  output reg [15:0] regRdata,
  input wire safetyChannelA,
  input wire safetyChannelB,
  input wire [15:0] driveStatusWord,
  input wire [NCH*16-1:0] analogSample,
  output wire torqueShutdown,
  output reg digitalOut,
  output reg [NCONS*16-1:0] consumerValue,
  output reg [NCH-1:0] wireBreak,
  output wire irq
);

  localparam NEV = 2 + NCH;
  localparam ST_IDLE = 3'b001;
  localparam ST_DIV = 3'b010;
  localparam ST_OUT = 3'b100;

  function [15:0] sat16;
    input signed [35:0] v;
    begin
      if (v > 36'sh00007FFF)
        sat16 = 16'h7FFF;
      else if (v < -36'sh000008000)
        sat16 = 16'h8000;
      else
        sat16 = v[15:0];
    end
  endfunction

  function [15:0] cfgReset;
    input [2:0] k;
    begin
      case (k)
        `DIO_K_P2X: cfgReset = `DIO_P2X_RST;
        `DIO_K_P2Y: cfgReset = `DIO_P2Y_RST;
        `DIO_K_WBTH: cfgReset = `DIO_WBTH_RST;
        `DIO_K_DBAND: cfgReset = `DIO_DBAND_RST;
        default: cfgReset = `DIO_CFG_RST;
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Register file

  reg [15:0] ctrl;
  reg [15:0] misTol;
  reg [15:0] outCfg;
  reg [15:0] refQ;
  reg [NEV-1:0] irqStat;
  reg [NEV-1:0] irqMask;
  reg [15:0] chCfg [0:NCH*8-1];
  wire [NEV-1:0] events;
  wire [NCH*16-1:0] scaledFlat;
  wire [NCH-1:0] wbFlat;
  wire chWin = (regAddr[7:6] == `DIO_CH_WIN) && (regAddr[5:5] < NCH);
  wire valWin = (regAddr[7:6] == `DIO_VAL_WIN) && (regAddr[5:2] < NCH);
  wire [3:0] cfgIdx = {regAddr[5], regAddr[4:2]};
  wire [3:0] valIdx = regAddr[5:2];
  wire irqClr = regWrite && (regAddr == `DIO_IRQSTAT);
  reg safeSelected;
  reg misFault;
  reg chA;
  reg chB;
  integer i;

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl <= `DIO_CTRL_RST;
      misTol <= `DIO_MISTOL_RST;
      outCfg <= `DIO_OUTCFG_RST;
      refQ <= `DIO_REFQ_RST;
      irqMask <= {NEV{1'b0}};
      for (i = 0; i < NCH*8; i = i + 1) begin
        chCfg[i] <= cfgReset(i[2:0]);
      end
    end else if (regWrite) begin
      case (regAddr)
        `DIO_CTRL: ctrl <= regWdata;
        `DIO_MISTOL: misTol <= regWdata;
        `DIO_OUTCFG: outCfg <= regWdata;
        `DIO_REFQ: refQ <= regWdata;
        `DIO_IRQMASK: irqMask <= regWdata[NEV-1:0];
        default: begin
          if (chWin) begin
            chCfg[cfgIdx] <= regWdata;
          end
        end
      endcase
    end
  end

  // Set wins over a write-one clear in the same cycle
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      irqStat <= {NEV{1'b0}};
    end else begin
      irqStat <= (irqStat & ~(irqClr ? regWdata[NEV-1:0] : {NEV{1'b0}})) | events;
    end
  end

  assign irq = |(irqStat & irqMask);

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      regRdata <= 16'h0000;
    end else if (regRead) begin
      case (regAddr)
        `DIO_CTRL: regRdata <= ctrl;
        `DIO_MISTOL: regRdata <= misTol;
        `DIO_OUTCFG: regRdata <= outCfg;
        `DIO_REFQ: regRdata <= refQ;
        `DIO_STATUS: regRdata <= {{(12-NCH){1'b0}}, wireBreak, chB, chA, misFault, torqueShutdown};
        `DIO_IRQSTAT: regRdata <= {{(16-NEV){1'b0}}, irqStat};
        `DIO_IRQMASK: regRdata <= {{(16-NEV){1'b0}}, irqMask};
        default: begin
          if (chWin)
            regRdata <= chCfg[cfgIdx];
          else if (valWin)
            regRdata <= scaledFlat[valIdx*16 +: 16];
          else
            regRdata <= 16'h0000;
        end
      endcase
    end else begin
      regRdata <= 16'h0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Paired safety input

  reg syncA0;
  reg syncB0;
  reg [15:0] misCount;
  reg shutPrev;
  reg faultPrev;
  wire mismatch = chA ^ chB;

  // Reset state selects the safety function until the pins have been seen
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      syncA0 <= 1'b0;
      syncB0 <= 1'b0;
      chA <= 1'b0;
      chB <= 1'b0;
    end else begin
      syncA0 <= safetyChannelA;
      syncB0 <= safetyChannelB;
      chA <= syncA0;
      chB <= syncB0;
    end
  end

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      safeSelected <= 1'b1;
      misCount <= 16'h0000;
      misFault <= 1'b0;
    end else if (!mismatch) begin
      misCount <= 16'h0000;
      misFault <= 1'b0;
      safeSelected <= ~chA;
    end else if (misCount < misTol) begin
      misCount <= misCount + 16'h0001;
    end else begin
      misFault <= 1'b1;
    end
  end

  // A persisting mismatch is treated as a selection: the safe side
  assign torqueShutdown = ctrl[`DIO_CTRL_STO_EN] & (safeSelected | misFault);

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      shutPrev <= 1'b0;
      faultPrev <= 1'b0;
    end else begin
      shutPrev <= torqueShutdown;
      faultPrev <= misFault;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Digital output

  wire [4:0] outSrc = outCfg[`DIO_OUT_SRC_HI:0];
  wire [4:0] outBit = outSrc - 5'h01;
  wire outValid = (outSrc != 5'h00) && (outSrc <= 5'h10);

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n)
      digitalOut <= 1'b0;
    else if (!outValid)
      digitalOut <= 1'b0;
    else
      digitalOut <= driveStatusWord[outBit[3:0]] ^ outCfg[`DIO_OUT_INV];
  end

  ////////////////////////////////////////////////////////////////////////////
  // Analog channels

  genvar g;
  generate
    for (g = 0; g < NCH; g = g + 1) begin : chan
      wire signed [15:0] x = analogSample[g*16 +: 16];
      wire signed [15:0] p1x = chCfg[g*8+`DIO_K_P1X];
      wire signed [15:0] p1y = chCfg[g*8+`DIO_K_P1Y];
      wire signed [15:0] p2x = chCfg[g*8+`DIO_K_P2X];
      wire signed [15:0] p2y = chCfg[g*8+`DIO_K_P2Y];
      wire signed [15:0] wbTh = chCfg[g*8+`DIO_K_WBTH];
      wire [3:0] smSh = chCfg[g*8+`DIO_K_SMOOTH][3:0];
      wire [15:0] dBand = chCfg[g*8+`DIO_K_DBAND];
      reg signed [23:0] acc;
      reg signed [15:0] scaled;
      reg wbPrev;
      reg [2:0] state;
      reg [33:0] quo;
      reg [16:0] rem;
      reg [16:0] dvs;
      reg negQ;
      reg [5:0] steps;
      reg signed [15:0] yPct;
      wire signed [24:0] diff = {x[15], x, 8'h00} - {acc[23], acc};
      wire signed [24:0] step = diff >>> smSh;
      wire signed [15:0] sm = acc[23:8];
      wire signed [16:0] smx = {sm[15], sm};
      wire signed [16:0] absv = smx[16] ? -smx : smx;
      wire signed [15:0] dz = (absv <= $signed({1'b0, dBand})) ? 16'sh0000 : sm;
      wire signed [16:0] dx = {dz[15], dz} - {p1x[15], p1x};
      wire signed [16:0] dy = {p2y[15], p2y} - {p1y[15], p1y};
      wire signed [16:0] den = {p2x[15], p2x} - {p1x[15], p1x};
      wire signed [33:0] num = dx * dy;
      wire [17:0] trial = {rem, quo[33]} - {1'b0, dvs};
      wire signed [35:0] qs = negQ ? -$signed({2'b00, quo}) : $signed({2'b00, quo});
      wire signed [35:0] ySum = qs + {{20{p1y[15]}}, p1y};
      wire signed [32:0] prod = yPct * $signed({1'b0, refQ});
      // Concatenation is unsigned; cast it so the shift keeps the sign
      wire signed [35:0] prodSh = $signed({{3{prod[32]}}, prod}) >>> `DIO_PCT_SHIFT;

      always @(posedge mclk or negedge rst_n) begin
        if (!rst_n)
          acc <= 24'sh000000;
        else if (smSh == 4'h0)
          acc <= {x, 8'h00};
        else
          acc <= acc + step[23:0];
      end

      // Scaled values refresh once per divider pass, about 37 cycles
      always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
          state <= ST_IDLE;
          quo <= 34'h000000000;
          rem <= 17'h00000;
          dvs <= 17'h00000;
          negQ <= 1'b0;
          steps <= 6'h00;
          yPct <= 16'sh0000;
          scaled <= 16'sh0000;
        end else begin
          case (state)
            ST_IDLE: begin
              rem <= 17'h00000;
              negQ <= num[33] ^ den[16];
              dvs <= den[16] ? -den : den;
              quo <= (den == 17'sh00000) ? 34'h000000000 : (num[33] ? -num : num);
              steps <= (den == 17'sh00000) ? 6'h00 : `DIO_DIV_STEPS;
              state <= ST_DIV;
            end
            ST_DIV: begin
              if (steps == 6'h00) begin
                yPct <= sat16(ySum);
                state <= ST_OUT;
              end else begin
                steps <= steps - 6'h01;
                if (!trial[17]) begin
                  rem <= trial[16:0];
                  quo <= {quo[32:0], 1'b1};
                end else begin
                  rem <= {rem[15:0], quo[33]};
                  quo <= {quo[32:0], 1'b0};
                end
              end
            end
            ST_OUT: begin
              scaled <= sat16(prodSh);
              state <= ST_IDLE;
            end
            default: state <= ST_IDLE;
          endcase
        end
      end

      always @(posedge mclk or negedge rst_n) begin
        if (!rst_n)
          wbPrev <= 1'b0;
        else
          wbPrev <= wbFlat[g];
      end

      // Raw level is compared so smoothing cannot hide a break
      assign wbFlat[g] = (x < wbTh);
      assign events[`DIO_EV_WB+g] = wbFlat[g] & ~wbPrev;
      assign scaledFlat[g*16 +: 16] = scaled;
    end
  endgenerate

  assign events[`DIO_EV_FAULT] = misFault & ~faultPrev;
  assign events[`DIO_EV_SHUT] = torqueShutdown & ~shutPrev;

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n)
      wireBreak <= {NCH{1'b0}};
    else
      wireBreak <= wbFlat;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Consumer routing; the lower channel wins when two pick one consumer

  reg [NCONS*16-1:0] next_consumerValue;
  integer k;
  integer r;

  always @* begin
    next_consumerValue = {(NCONS*16){1'b0}};
    r = 0;
    for (k = NCH - 1; k >= 0; k = k - 1) begin
      r = chCfg[k*8+`DIO_K_ROUTE][2:0];
      if ((r != 0) && (r <= NCONS))
        next_consumerValue[(r-1)*16 +: 16] = scaledFlat[k*16 +: 16];
    end
  end

  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n)
      consumerValue <= {(NCONS*16){1'b0}};
    else
      consumerValue <= next_consumerValue;
  end

endmodule

// ---- tb/dio_cond_monitor.sv ----
// Checker for the conditioning block, bound to its top ports.
// Assumes shadow copies of written settings track the block's own registers.
`timescale 1ns/1ps
module dio_cond_monitor #(
  parameter NCH = 2,
  parameter NCONS = 4
) (
  input wire mclk,
  input wire rst_n,
  input wire [7:0] regAddr,
  input wire [15:0] regWdata,
  input wire regWrite,
  input wire regRead,
  input wire [15:0] regRdata,
  input wire safetyChannelA,
  input wire safetyChannelB,
  input wire [15:0] driveStatusWord,
  input wire [NCH*16-1:0] analogSample,
  input wire torqueShutdown,
  input wire digitalOut,
  input wire [NCH-1:0] wireBreak,
  input wire irq
);
  reg en;
  reg [15:0] tol;
  reg [15:0] mask;
  reg [15:0] thr0;
  reg [15:0] misCnt;
  reg [8:0] cfg;
  wire [4:0] src = cfg[4:0];
  // Source off forces the pin inactive whatever the inversion
  wire selBit = (src != 5'h00 && src <= 5'h10) ? (driveStatusWord[src - 5'h01] ^ cfg[8]) : 1'b0;
  wire wbNow = $signed(analogSample[15:0]) < $signed(thr0);
  ////////////////////
  // Raw pin mismatch is counted, so the bound below carries slack for the sync stages
  always @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      en <= 1'b0;
      tol <= 16'h03E8;
      mask <= 16'h0000;
      thr0 <= 16'h8000;
      cfg <= 9'h000;
      misCnt <= 16'h0000;
    end else begin
      misCnt <= (safetyChannelA != safetyChannelB) ? misCnt + 16'h0001 : 16'h0000;
      if (regWrite) begin
        case (regAddr)
          8'h00: en <= regWdata[0];
          8'h04: tol <= regWdata;
          8'h08: cfg <= regWdata[8:0];
          8'h18: mask <= regWdata;
          8'h50: thr0 <= regWdata;
          default: begin
          end
        endcase
      end
    end
  end
  ////////////////////
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  rd_idle_a: assert property (!$past(regRead) |-> regRdata == 16'h0000)
    else $error("read data outside its cycle");
  shut_off_a: assert property (!en |-> !torqueShutdown)
    else $error("shutdown while disabled");
  shut_low_a: assert property ((en && !safetyChannelA && !safetyChannelB) [*4] |-> torqueShutdown)
    else $error("both low without shutdown");
  shut_high_a: assert property ((en && safetyChannelA && safetyChannelB) [*5] |-> !torqueShutdown)
    else $error("both high with shutdown");
  mis_force_a: assert property (en && misCnt > tol + 16'h0005 |-> torqueShutdown)
    else $error("lasting mismatch not reported");
  irq_mask_a: assert property (mask == 16'h0000 |-> !irq)
    else $error("interrupt while all masked");
  out_follow_a: assert property (digitalOut == $past(selBit))
    else $error("digital output wrong");
  wire_brk_a: assert property (wireBreak[0] == $past(wbNow))
    else $error("wire break flag wrong");
  cover property (en && torqueShutdown);
  cover property (irq);
  cover property (wireBreak[0]);
endmodule

// ---- tb/dio_safety_src.sv ----
// Safety sensor model: drives both channels from one level.
// Assumes the bench asks for channel skew only where a mismatch is wanted.
`timescale 1ns/1ps
module dio_safety_src (
  input wire mclk,
  input wire level,
  input wire [7:0] skew,
  output reg chA = 1'b1,
  output reg chB = 1'b1
);
  always @(level) begin
    chA <= level;
    repeat (skew) @(posedge mclk);
    chB <= level;
  end
endmodule

// ---- tb/dio_signal_cond_tb_top.sv ----
// Testbench top: register bus tasks and one task per scenario.
// Assumes the safety source model and one 100 MHz clock.
`timescale 1ns/1ps
module dio_signal_cond_tb_top;
  reg mclk = 1'b0;
  reg rst_n = 1'b0;
  reg [7:0] regAddr = 8'h00;
  reg [15:0] regWdata = 16'h0000;
  reg regWrite = 1'b0;
  reg regRead = 1'b0;
  reg safeLevel = 1'b1;
  reg [7:0] skew = 8'h00;
  reg [15:0] sw = 16'hA5C3;
  reg [31:0] ana = 32'h00000000;
  wire [15:0] regRdata;
  wire chA, chB, shut, dout, irq;
  wire [63:0] cons;
  wire [1:0] wb;
  integer numErrors = 0;
  integer compares = 0;
  integer s;
  dio_signal_cond #(.NCH(2), .NCONS(4)) dio_signal_cond_i (.mclk(mclk), .rst_n(rst_n), .regAddr(regAddr),
    .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .safetyChannelA(chA),
    .safetyChannelB(chB), .driveStatusWord(sw), .analogSample(ana), .torqueShutdown(shut), .digitalOut(dout),
    .consumerValue(cons), .wireBreak(wb), .irq(irq));
  dio_safety_src dio_safety_src_i (.mclk(mclk), .level(safeLevel), .skew(skew), .chA(chA), .chB(chB));
  ////////////////////
  task chk(input [63:0] nm, input [15:0] seen, input [15:0] exp);
    begin
      compares = compares + 1;
      if (seen !== exp) begin
        numErrors = numErrors + 1;
        $display("MISMATCH %0s exp %h seen %h", nm, exp, seen);
      end
    end
  endtask
  task cyc(input integer n);
    begin
      repeat (n) @(posedge mclk);
      #1;
    end
  endtask
  task wr(input [7:0] a, input [15:0] d);
    begin
      @(posedge mclk);
      regAddr <= a;
      regWdata <= d;
      regWrite <= 1'b1;
      @(posedge mclk);
      regWrite <= 1'b0;
    end
  endtask
  task rd(input [7:0] a, input [15:0] e, input [63:0] nm);
    begin
      @(posedge mclk);
      regAddr <= a;
      regRead <= 1'b1;
      @(posedge mclk);
      regRead <= 1'b0;
      #1 chk(nm, regRdata, e);
    end
  endtask
  task lvl(input v, input [7:0] k);
    begin
      @(posedge mclk);
      skew <= k;
      safeLevel <= v;
    end
  endtask
  task band(input [15:0] x, input [15:0] e);
    begin
      @(posedge mclk) ana[15:0] <= x;
      cyc(100);
      chk("cons1", cons[31:16], e);
    end
  endtask
  ////////////////////
  task t_reset;
    begin
      cyc(1);
      chk("shut", shut, 16'h0000);
      rd(8'h5C, 16'h0000, "band0");
      rd(8'h7C, 16'h0000, "band1");
      rd(8'h3C, 16'h0000, "unmap");
    end
  endtask
  task t_safe;
    begin
      lvl(1'b0, 8'h00);
      cyc(6);
      chk("shut", shut, 16'h0000);
      wr(8'h18, 16'h0002);
      wr(8'h00, 16'h0001);
      cyc(2);
      chk("shut", shut, 16'h0001);
      chk("irq", irq, 16'h0001);
      wr(8'h14, 16'h0002);
      cyc(2);
      chk("irq", irq, 16'h0000);
      lvl(1'b1, 8'h00);
      cyc(2);
      chk("shut", shut, 16'h0001);
      cyc(1);
      chk("shut", shut, 16'h0000);
    end
  endtask
  task t_mis;
    begin
      wr(8'h04, 16'h0004);
      lvl(1'b0, 8'h14);
      cyc(4);
      chk("shut", shut, 16'h0000);
      cyc(6);
      chk("shut", shut, 16'h0001);
      rd(8'h10, 16'h000B, "status");
      cyc(20);
      wr(8'h14, 16'h0007);
      lvl(1'b1, 8'h03);
      cyc(10);
      rd(8'h14, 16'h0000, "irqstat");
    end
  endtask
  task t_out;
    begin
      // Sources 0..17 with and without inversion; 17 lies past the last status bit
      for (s = 0; s < 36; s = s + 1) begin
        wr(8'h08, {7'h00, s[0], 3'h0, s[5:1]});
        cyc(2);
        chk("dout", dout, (s[5:1] >= 1 && s[5:1] <= 16) ? (sw[s[5:1] - 1] ^ s[0]) : 1'b0);
      end
    end
  endtask
  task t_ana;
    begin
      @(posedge mclk) ana <= 32'h13881388;
      wr(8'h54, 16'h0002);
      wr(8'h6C, 16'h2000);
      wr(8'h74, 16'h0004);
      cyc(100);
      chk("cons1", cons[31:16], 16'h2000);
      chk("cons3", cons[63:48], 16'h1000);
      chk("cons0", cons[15:0], 16'h0000);
      rd(8'h84, 16'h1000, "val1");
      @(posedge mclk) ana[15:0] <= 16'hEC78;
      wr(8'h0C, 16'h2000);
      cyc(100);
      chk("cons1", cons[31:16], 16'hF000);
      wr(8'h0C, 16'h4000);
      wr(8'h5C, 16'h0064);
      band(16'hFF9C, 16'h0000);
      band(16'h0065, 16'h00A5);
      wr(8'h50, 16'h0000);
      wr(8'h18, 16'h0004);
      @(posedge mclk) ana[15:0] <= 16'hFFFF;
      cyc(3);
      chk("wbrk", wb, 16'h0001);
      chk("irq", irq, 16'h0001);
      @(posedge mclk) ana[15:0] <= 16'h0000;
      wr(8'h14, 16'h0004);
      cyc(3);
      chk("wbrk", wb, 16'h0000);
      chk("irq", irq, 16'h0000);
      // Smoothed channel must lag a step and settle on the new level later
      wr(8'h78, 16'h0004);
      @(posedge mclk) ana[31:16] <= 16'h0000;
      cyc(60);
      chk("smooth", {15'h0000, cons[63:48] != 16'h0000}, 16'h0001);
      cyc(400);
      chk("cons3", cons[63:48], 16'h0000);
    end
  endtask
  task finish_test;
    begin
      $display("errors %0d compares %0d", numErrors, compares);
      if (numErrors == 0 && compares > 0)
        $display("ALL TESTS PASSED");
      else
        $display("TESTS FAILED");
      $finish;
    end
  endtask
  ////////////////////
  initial forever #5 mclk = ~mclk;
  initial begin
    repeat (20) @(posedge mclk);
    rst_n <= 1'b1;
    t_reset;
    t_safe;
    t_mis;
    t_out;
    t_ana;
    finish_test;
  end
  // Whole run is under 2000 cycles, so this only trips on a hang
  initial begin
    #100000;
    numErrors = numErrors + 1;
    finish_test;
  end
endmodule
bind dio_signal_cond dio_cond_monitor #(.NCH(NCH), .NCONS(NCONS)) dio_cond_monitor_i (.mclk(mclk), .rst_n(rst_n),
  .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
  .safetyChannelA(safetyChannelA), .safetyChannelB(safetyChannelB), .driveStatusWord(driveStatusWord),
  .analogSample(analogSample), .torqueShutdown(torqueShutdown), .digitalOut(digitalOut),
  .wireBreak(wireBreak), .irq(irq));
